// ==== hdl/cmbt_ctrl.sv ====
// Contract
// - Read-only status bit shows whether controller is synced to bus.
// - Timer link bit picks controller timer output or port pin.
// - Sleep acknowledge set in sleep, cleared on bus activity.
// - Sleep request asks for sleep; acknowledge confirms entry.
// - Setting soft reset enters it at once, drops bus sync.
// - Soft reset holds control 0, flags, enables, tx control at reset.
// - Config, timing and acceptance registers writable only in soft reset.
// - Soft reset leaves both error counters untouched.
// - Resync after 11 recessive bits, or 128 times that if bus-off.
// - Loop-back feeds tx to rx, ignores rx pin, tx pin recessive.
// - Loop-back takes own frame as received, ignores ack slot.
// - Wake filter mode needs long dominant pulse, else any falling edge.
// - Clock select bit: 1 generator output, 0 crystal by two.
// - Jump width codes 0 to 3 give 1 to 4 quanta.
// - Prescaler code plus one divides clock into time quantum.
// - Sampling bit selects three-sample majority or single sample.
// - Segment one code plus one, segment two code plus one.
// - Bit time is prescaler over clock times quanta per bit.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module cmbt_ctrl
  import cmbt_pkg::*;
#(
  parameter int unsigned WUP_CYCLES = WUP_FILTER_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData_q,
  // CAN pins
  input  wire logic        canRx,
  output logic             canTx_q,
  // Protocol engine side
  input  wire logic        engTxBit,
  input  wire logic        engTimerOut,
  input  wire logic        engBusOff,
  input  wire logic [6:0]  rxFlagSet,
  input  wire logic [2:0]  txeSet,
  input  wire logic [2:0]  abtakSet,
  input  wire logic [1:0]  idHit,
  input  wire logic [7:0]  rxErrCnt,
  input  wire logic [7:0]  txErrCnt,
  // Timer link
  input  wire logic        portTimerIn,
  output logic             timerIn_q,
  // Status and mode outputs
  output logic             soft_reset_q,
  output logic             busSynced_q,
  output logic             slpAck_q,
  output logic             wakeup_q,
  output logic             clkSel_q,
  output logic             loopBack_q,
  output logic             tqTick_q,
  output logic             samplePulse_q,
  output logic             rxBit_q,
  output logic             busOffDone_q
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  localparam int DW = $clog2(WUP_CYCLES + 1);
  logic       tlnk_q, slpReq_q, wakeFilt_q;
  logic [7:0] btr0_q, btr1_q, rflg_q, rier_q, tflg_q, tcr_q;
  logic [1:0] idam_q;
  logic [7:0] acode0_q, acode1_q, amask0_q, amask1_q;
  logic [5:0] tqCnt_q;
  logic [4:0] bitTq_q;
  logic [2:0] ext_q;
  logic [1:0] smp_q;
  logic [3:0] recCnt_q;
  logic [6:0] occCnt_q;
  logic [DW-1:0] domCnt_q;
  logic       rxPrev_q;
  cmbt_sync_t syncSt_q, syncSt_d;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire wrMcr0 = regWr && (regAddr == ADDR_MCR0);
  wire wrRflg = regWr && (regAddr == ADDR_RFLG);
  wire wrRier = regWr && (regAddr == ADDR_RIER);
  wire wrTflg = regWr && (regAddr == ADDR_TFLG);
  wire wrTcr  = regWr && (regAddr == ADDR_TCR);
  // ignored unless soft reset is set
  wire pw      = regWr && soft_reset_q;
  wire wrMcr1  = pw && (regAddr == ADDR_MCR1);
  wire wrBtr0  = pw && (regAddr == ADDR_BTR0);
  wire wrBtr1  = pw && (regAddr == ADDR_BTR1);
  wire wrActl  = pw && (regAddr == ADDR_ACTL);
  wire wrCode0 = pw && (regAddr == ADDR_ACODE0);
  wire wrCode1 = pw && (regAddr == ADDR_ACODE1);
  wire wrMask0 = pw && (regAddr == ADDR_AMASK0);
  wire wrMask1 = pw && (regAddr == ADDR_AMASK1);

  // ---------------------------------------------------------------
  // Module control 0
  // ---------------------------------------------------------------
  // soft reset takes effect on the write edge
  wire soft_reset_d = wrMcr0 ? regWrData[MCR0_SOFTRST] : soft_reset_q;
  wire inSoft   = soft_reset_q || soft_reset_d;
  wire rxSrc;
  wire wakeEvt;
  // other control bits pinned while in soft reset
  // clearing soft reset cannot also set other bits
  wire tlnk_d   = inSoft ? 1'b0
                : (wrMcr0 ? regWrData[MCR0_TLNK] : tlnk_q);
  // request drops on wakeup so sleep is not re-entered
  wire slpReq_d = inSoft ? 1'b0
                : wrMcr0 ? regWrData[MCR0_SLPREQ]
                : (wakeEvt ? 1'b0 : slpReq_q);
  // enter only on an idle bus, leave on activity
  wire slpAck_d = inSoft ? 1'b0
                : slpAck_q ? (slpReq_q && !wakeEvt)
                : (slpReq_q && rxSrc);

  // Control 0 flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_q <= SOFTRST_RST;
      tlnk_q   <= 1'b0;
      slpReq_q <= 1'b0;
      slpAck_q <= 1'b0;
    end else begin
      soft_reset_q <= soft_reset_d;
      tlnk_q   <= tlnk_d;
      slpReq_q <= slpReq_d;
      slpAck_q <= slpAck_d;
    end
  end

  // ---------------------------------------------------------------
  // Protected configuration registers
  // ---------------------------------------------------------------
  // Written only while in soft reset, so timing never shifts mid-frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {loopBack_q, wakeFilt_q, clkSel_q} <= 3'h0;
      btr0_q   <= ZERO_RST;
      btr1_q   <= ZERO_RST;
      idam_q   <= 2'h0;
      acode0_q <= ZERO_RST;
      acode1_q <= ZERO_RST;
      amask0_q <= ZERO_RST;
      amask1_q <= ZERO_RST;
    end else begin
      if (wrMcr1) begin
        loopBack_q <= regWrData[MCR1_LOOP];
        wakeFilt_q <= regWrData[MCR1_WFILT];
        clkSel_q   <= regWrData[MCR1_CLKSEL];
      end
      if (wrBtr0)  btr0_q   <= regWrData;
      if (wrBtr1)  btr1_q   <= regWrData;
      if (wrActl)  idam_q   <= regWrData[ACTL_IDAM_HI:ACTL_IDAM_LO];
      if (wrCode0) acode0_q <= regWrData;
      if (wrCode1) acode1_q <= regWrData;
      if (wrMask0) amask0_q <= regWrData;
      if (wrMask1) amask1_q <= regWrData;
    end
  end

  // ---------------------------------------------------------------
  // Flag and enable registers
  // ---------------------------------------------------------------
  wire [7:0] rClr   = wrRflg ? regWrData : ZERO_RST;
  wire [2:0] tClr   = wrTflg ? regWrData[TXE_HI:0] : 3'h0;
  wire [2:0] txeNxt = (tflg_q[TXE_HI:0] & ~tClr) | txeSet;
  // Clearing an empty flag also clears its abort flag; set wins
  wire [2:0] abkNxt = (tflg_q[FLD3_HI:FLD3_LO] & ~tClr) | abtakSet;
  wire [7:0] tcrW   = wrTcr ? regWrData : tcr_q;
  // Abort request retires when its buffer reports empty
  wire [2:0] abrNxt = tcrW[FLD3_HI:FLD3_LO] & ~txeSet;

  // held at reset value during soft reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rflg_q <= ZERO_RST;
      rier_q <= ZERO_RST;
      tflg_q <= TFLG_RST;
      tcr_q  <= ZERO_RST;
    end else if (soft_reset_q) begin
      rflg_q <= ZERO_RST;
      rier_q <= ZERO_RST;
      tflg_q <= TFLG_RST;
      tcr_q  <= ZERO_RST;
    end else begin
      rflg_q <= (rflg_q & ~rClr) | {wakeEvt, rxFlagSet};
      if (wrRier) rier_q <= regWrData;
      tflg_q <= {1'b0, abkNxt, 1'b0, txeNxt};
      tcr_q  <= {1'b0, abrNxt, 1'b0, tcrW[TXE_HI:0]};
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] rdMux;
  // Unmapped and reserved bytes read as zero
  always_comb begin
    case (regAddr)
      ADDR_MCR0:   rdMux = {3'h0, busSynced_q, tlnk_q, slpAck_q,
                            slpReq_q, soft_reset_q};
      ADDR_MCR1:   rdMux = {5'h00, loopBack_q, wakeFilt_q, clkSel_q};
      ADDR_BTR0:   rdMux = btr0_q;
      ADDR_BTR1:   rdMux = btr1_q;
      ADDR_RFLG:   rdMux = rflg_q;
      ADDR_RIER:   rdMux = rier_q;
      ADDR_TFLG:   rdMux = tflg_q;
      ADDR_TCR:    rdMux = tcr_q;
      ADDR_ACTL:   rdMux = {2'h0, idam_q, 2'h0, idHit};
      // counters pass through, soft reset never touches them
      ADDR_RXERR:  rdMux = rxErrCnt;
      ADDR_TXERR:  rdMux = txErrCnt;
      ADDR_ACODE0: rdMux = acode0_q;
      ADDR_ACODE1: rdMux = acode1_q;
      ADDR_AMASK0: rdMux = amask0_q;
      ADDR_AMASK1: rdMux = amask1_q;
      default:     rdMux = ZERO_RST;
    endcase
  end

  // Read data stands for the one cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) regRdData_q <= ZERO_RST;
    else        regRdData_q <= regRd ? rdMux : ZERO_RST;
  end

  // ---------------------------------------------------------------
  // Pins, loop-back and timer link
  // ---------------------------------------------------------------
  // receiver sees own transmit stream, rx pin ignored
  // own frame arrives as if from a remote node
  assign rxSrc = loopBack_q ? engTxBit : canRx;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      canTx_q   <= 1'b1;
      timerIn_q <= 1'b0;
    end else begin
      // transmit pin parked recessive in loop-back
      canTx_q   <= loopBack_q ? 1'b1 : engTxBit;
      timerIn_q <= tlnk_q ? engTimerOut : portTimerIn;
    end
  end

  // ---------------------------------------------------------------
  // Wakeup detection
  // ---------------------------------------------------------------
  wire [DW-1:0] domMax = DW'(WUP_CYCLES - 1);
  wire [DW-1:0] domCnt_d = rxSrc ? '0
                         : (domCnt_q == domMax) ? domCnt_q
                         : domCnt_q + 1'b1;
  // filtered pulse length or plain falling edge
  wire wakeRaw = wakeFilt_q ? (!rxSrc && domCnt_q == domMax)
                            : (rxPrev_q && !rxSrc);
  assign wakeEvt = slpAck_q && wakeRaw;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      domCnt_q <= '0;
      rxPrev_q <= 1'b1;
      wakeup_q <= 1'b0;
    end else begin
      domCnt_q <= domCnt_d;
      rxPrev_q <= rxSrc;
      wakeup_q <= wakeEvt;
    end
  end

  // ---------------------------------------------------------------
  // Bit timing
  // ---------------------------------------------------------------
  // quantum is prescaler code plus one clocks
  wire [5:0] presc   = btr0_q[BTR0_PSC_HI:BTR0_PSC_LO];
  wire       tqTick  = !soft_reset_q && (tqCnt_q == presc);
  wire [2:0] jumpW   = {1'b0, btr0_q[BTR0_JMP_HI:BTR0_JMP_LO]} + 3'h1;
  // segment lengths are code plus one
  wire [4:0] seg1Len = {1'b0, btr1_q[BTR1_TS1_HI:BTR1_TS1_LO]} + 5'h01;
  wire [4:0] seg2Len = {2'h0, btr1_q[BTR1_TS2_HI:BTR1_TS2_LO]} + 5'h01;
  wire [4:0] seg1End = seg1Len + {2'h0, ext_q};
  // bit is sync quantum plus both segments
  wire [4:0] bitEnd  = seg1End + seg2Len;
  wire       edgeTq  = tqTick && smp_q[0] && !rxSrc;
  wire       sampleNow = tqTick && (bitTq_q == seg1End);
  wire       inSeg2  = bitTq_q > seg1End;
  wire [4:0] remain  = bitEnd - bitTq_q;
  wire [4:0] errTq   = (bitTq_q > {2'h0, jumpW}) ? {2'h0, jumpW} : bitTq_q;
  // majority over sample point and two earlier quanta
  wire       bitVal  = btr1_q[BTR1_MAJ]
                     ? cmbt_maj3(rxSrc, smp_q[0], smp_q[1]) : rxSrc;

  logic [4:0] bitTq_d;
  logic [2:0] ext_d;
  always_comb begin
    bitTq_d = bitTq_q;
    ext_d   = ext_q;
    if (tqTick) begin
      if (edgeTq && syncSt_q != SYNC_ON) begin
        bitTq_d = 5'h01;
        ext_d   = 3'h0;
      end else if (edgeTq && inSeg2 && remain <= {2'h0, jumpW}) begin
        bitTq_d = 5'h01;
        ext_d   = 3'h0;
      end else if (edgeTq && inSeg2) begin
        bitTq_d = bitTq_q + 5'h01 + {2'h0, jumpW};
      end else if (bitTq_q == bitEnd) begin
        bitTq_d = 5'h00;
        ext_d   = 3'h0;
      end else begin
        bitTq_d = bitTq_q + 5'h01;
        if (edgeTq && bitTq_q != 5'h00) ext_d = errTq[2:0];
      end
    end
  end

  // Timing flops, counters frozen at zero and samples at recessive in soft reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tqCnt_q <= 6'h00;
      bitTq_q <= 5'h00;
      ext_q   <= 3'h0;
      smp_q   <= 2'h3;
    end else if (soft_reset_q) begin
      tqCnt_q <= 6'h00;
      bitTq_q <= 5'h00;
      ext_q   <= 3'h0;
      smp_q   <= 2'h3;
    end else begin
      tqCnt_q <= tqTick ? 6'h00 : tqCnt_q + 6'h01;
      bitTq_q <= bitTq_d;
      ext_q   <= ext_d;
      if (tqTick) smp_q <= {smp_q[0], rxSrc};
    end
  end

  // Sampled bit towards the engine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tqTick_q      <= 1'b0;
      samplePulse_q <= 1'b0;
      rxBit_q       <= 1'b1;
    end else begin
      tqTick_q      <= tqTick;
      samplePulse_q <= sampleNow;
      if (sampleNow) rxBit_q <= bitVal;
    end
  end

  // ---------------------------------------------------------------
  // Bus synchronisation
  // ---------------------------------------------------------------
  localparam logic [3:0] REC_LAST = 4'(SYNC_RECESSIVE_BITS - 1);
  localparam logic [6:0] OCC_LAST = 7'(BUSOFF_OCCURRENCES - 1);
  wire recDone = sampleNow && bitVal && recCnt_q == REC_LAST;
  wire occDone = recDone && engBusOff && occCnt_q == OCC_LAST;

  // idle-bit counting, bus-off needs many idle runs
  always_comb begin
    case (syncSt_q)
      SYNC_OFF:  syncSt_d = SYNC_WAIT;
      SYNC_WAIT: syncSt_d = (recDone && (!engBusOff || occDone))
                          ? SYNC_ON : SYNC_WAIT;
      SYNC_ON:   syncSt_d = engBusOff ? SYNC_WAIT : SYNC_ON;
      default:   syncSt_d = SYNC_OFF;
    endcase
    // soft reset drops sync on the very write edge
    if (inSoft) syncSt_d = SYNC_OFF;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncSt_q <= SYNC_OFF;
      recCnt_q <= 4'h0;
      occCnt_q <= 7'h00;
    end else begin
      syncSt_q <= syncSt_d;
      if (syncSt_q != SYNC_WAIT || (sampleNow && !bitVal) || recDone)
        recCnt_q <= 4'h0;
      else if (sampleNow)
        recCnt_q <= recCnt_q + 4'h1;
      if (syncSt_q != SYNC_WAIT || !engBusOff)
        occCnt_q <= 7'h00;
      else if (recDone)
        occCnt_q <= occCnt_q + 7'h01;
    end
  end

  // status bit registered from the next-state value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busSynced_q  <= 1'b0;
      busOffDone_q <= 1'b0;
    end else begin
      busSynced_q  <= syncSt_d == SYNC_ON;
      busOffDone_q <= syncSt_q == SYNC_WAIT && occDone;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_soft_hold: assert property (
    soft_reset_q |=> rflg_q == ZERO_RST && rier_q == ZERO_RST &&
      tflg_q == TFLG_RST && tcr_q == ZERO_RST && !tlnk_q && !slpReq_q)
    else $error("soft reset did not hold registers");
  a_prot_ignore: assert property (
    regWr && regAddr == ADDR_BTR0 && !soft_reset_q |=> $stable(btr0_q))
    else $error("protected write taken outside soft reset");
  a_prot_accept: assert property (
    regWr && regAddr == ADDR_BTR1 && soft_reset_q
      |=> btr1_q == $past(regWrData))
    else $error("protected write lost in soft reset");
  a_sync_drop: assert property (
    soft_reset_q |=> !busSynced_q ##1 !busSynced_q)
    else $error("sync kept during soft reset");
  a_sync_idle: assert property (
    $rose(busSynced_q) && !$past(engBusOff)
      |-> $past(recCnt_q, 2) == REC_LAST)
    else $error("sync without eleven idle bits");
  a_busoff_wait: assert property (
    busOffDone_q |-> $past(occCnt_q) == OCC_LAST && busSynced_q)
    else $error("bus-off recovery count wrong");
  a_loop_tx: assert property (
    loopBack_q |=> canTx_q)
    else $error("tx pin not recessive in loop-back");
  a_timer_link: assert property (
    tlnk_q |=> timerIn_q == $past(engTimerOut))
    else $error("timer input not linked");
  a_sleep_wake: assert property (
    wakeEvt |=> !slpAck_q && rflg_q[RFLG_WAKE] && wakeup_q)
    else $error("wakeup did not leave sleep");
  a_tq_spacing: assert property (
    tqTick && presc != 6'h00 |=> !tqTick)
    else $error("quantum tick too early");
  a_triple_vote: assert property (
    sampleNow && btr1_q[BTR1_MAJ] && smp_q == 2'h0
      |=> samplePulse_q && !rxBit_q)
    else $error("majority vote ignored");

  c_synced:   cover property ($rose(busSynced_q));
  c_busoff:   cover property (busOffDone_q);
  c_wake:     cover property (wakeup_q && wakeFilt_q);
  c_loopback: cover property (loopBack_q && samplePulse_q);

endmodule : cmbt_ctrl

// ==== hdl/cmbt_pkg.sv ====
package cmbt_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_MCR0   = 16'h0500;
  localparam logic [15:0] ADDR_MCR1   = 16'h0501;
  localparam logic [15:0] ADDR_BTR0   = 16'h0502;
  localparam logic [15:0] ADDR_BTR1   = 16'h0503;
  localparam logic [15:0] ADDR_RFLG   = 16'h0504;
  localparam logic [15:0] ADDR_RIER   = 16'h0505;
  localparam logic [15:0] ADDR_TFLG   = 16'h0506;
  localparam logic [15:0] ADDR_TCR    = 16'h0507;
  localparam logic [15:0] ADDR_ACTL   = 16'h0508;
  localparam logic [15:0] ADDR_RXERR  = 16'h050E;
  localparam logic [15:0] ADDR_TXERR  = 16'h050F;
  localparam logic [15:0] ADDR_ACODE0 = 16'h0510;
  localparam logic [15:0] ADDR_ACODE1 = 16'h0511;
  localparam logic [15:0] ADDR_AMASK0 = 16'h0514;
  localparam logic [15:0] ADDR_AMASK1 = 16'h0515;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MCR0_SYNCED = 4;
  localparam int MCR0_TLNK   = 3;
  localparam int MCR0_SLPACK = 2;
  localparam int MCR0_SLPREQ = 1;
  localparam int MCR0_SOFTRST = 0;
  localparam int MCR1_LOOP   = 2;
  localparam int MCR1_WFILT  = 1;
  localparam int MCR1_CLKSEL = 0;
  localparam int BTR0_JMP_HI = 7;
  localparam int BTR0_JMP_LO = 6;
  localparam int BTR0_PSC_HI = 5;
  localparam int BTR0_PSC_LO = 0;
  localparam int BTR1_MAJ    = 7;
  localparam int BTR1_TS2_HI = 6;
  localparam int BTR1_TS2_LO = 4;
  localparam int BTR1_TS1_HI = 3;
  localparam int BTR1_TS1_LO = 0;
  localparam int RFLG_WAKE   = 7;
  localparam int FLD3_HI     = 6;
  localparam int FLD3_LO     = 4;
  localparam int TXE_HI      = 2;
  localparam int ACTL_IDAM_HI = 5;
  localparam int ACTL_IDAM_LO = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic       SOFTRST_RST = 1'b1;
  localparam logic [7:0] ZERO_RST    = 8'h00;
  localparam logic [7:0] TFLG_RST    = 8'h07;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SYNC_RECESSIVE_BITS = 11;
  localparam int BUSOFF_OCCURRENCES  = 128;
  localparam int SYS_CLK_MHZ         = 200;
  localparam int WUP_FILTER_NS       = 2000;
  localparam int WUP_RAW =
    (WUP_FILTER_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int WUP_FILTER_CYC = (WUP_RAW < 1) ? 1 : WUP_RAW;

  // Bus synchronisation states
  typedef enum logic [1:0] {
    SYNC_OFF  = 2'b00,
    SYNC_WAIT = 2'b01,
    SYNC_ON   = 2'b10
  } cmbt_sync_t;

  // Majority of three samples
  function automatic logic cmbt_maj3(input logic a, input logic b,
                                     input logic c);
    cmbt_maj3 = (a & b) | (a & c) | (b & c);
  endfunction : cmbt_maj3

endpackage : cmbt_pkg

// ==== tb/cmbt_can_node.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Remote bus node
// ---------------------------------------------------------------
module cmbt_can_node (
  // Clock
  input  wire logic sys_clk,
  // Drive request from the bench
  input  wire logic dominant,
  // Bus level seen by the device
  output logic      canRx
);
  // Released bus returns recessive through its termination
  initial begin
    canRx = 1'b1;
    forever @(posedge sys_clk) canRx <= ~dominant;
  end
endmodule : cmbt_can_node

// ==== tb/can_mode_and_bit_timing_control_tb.sv ====
`timescale 1ns/1ps
module can_mode_and_bit_timing_control_tb;
  import cmbt_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        sys_clk, rst_n, regWr, regRd, engTxBit, rdSeen;
  logic        engTimerOut, portTimerIn, engBusOff, dominant, canRx;
  logic [15:0] regAddr;
  logic [7:0]  regWrData, regRdData_q, rxErr, txErr, btr0Val;
  logic [7:0]  expQ[$];
  logic        canTx_q, timerIn_q, busSynced_q, slpAck_q;
  int          bad_count, comparisons, seed, waitCnt;

  cmbt_ctrl #(.WUP_CYCLES(3)) u_cmbt_ctrl (
    .sys_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData_q, .canRx, .canTx_q, .engTxBit, .engTimerOut,
    .engBusOff, .rxFlagSet(7'h00), .txeSet(3'h0), .abtakSet(3'h0),
    .idHit(2'h0), .rxErrCnt(rxErr), .txErrCnt(txErr), .portTimerIn,
    .timerIn_q, .soft_reset_q(), .busSynced_q, .slpAck_q, .wakeup_q(),
    .clkSel_q(), .loopBack_q(), .tqTick_q(), .samplePulse_q(),
    .rxBit_q(), .busOffDone_q()
  );

  cmbt_can_node u_cmbt_can_node (.sys_clk, .dominant, .canRx);

  // ---------------------------------------------------------------
  // Checks and bus tasks
  // ---------------------------------------------------------------
  task automatic chkRead(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
    end
  endtask : chkRead

  task automatic chkPin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t pin got %b exp %b", $time, got, exp);
    end
  endtask : chkPin

  // Gap edge after each strobe keeps one assignment per time step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge sys_clk);
    regWr     <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rdSeen)
      chkRead(regRdData_q, expQ.pop_front());
    rdSeen <= regRd;
  end

  // ---------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    final_report();
  end

  initial begin
    seed = 32'h7ac97bb1;
    {rst_n, regWr, regRd, engBusOff, dominant} = '0;
    {engTxBit, engTimerOut, portTimerIn, regAddr, regWrData} = '0;
    rxErr = 8'($random(seed));
    txErr = 8'($random(seed));
    btr0Val = 8'($random(seed));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_MCR0, 8'h01);
    rd(ADDR_TFLG, TFLG_RST);
    wr(ADDR_RIER, 8'hFF);
    rd(ADDR_RIER, ZERO_RST);
    rd(16'h0509, 8'h00);
    rd(ADDR_RXERR, rxErr);
    wr(ADDR_BTR0, btr0Val);
    rd(ADDR_BTR0, btr0Val);
    wr(ADDR_BTR0, 8'h01);
    wr(ADDR_BTR1, 8'hA3);
    rd(ADDR_BTR1, 8'hA3);
    wr(ADDR_MCR1, 8'h05);
    rd(ADDR_MCR1, 8'h05);
    // Loop-back: tx pin stays recessive while engine bit and rx pin are dominant
    engTxBit <= 1'b0;
    dominant <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chkPin(canTx_q, 1'b1);
    engTxBit <= 1'b1;
    wr(ADDR_MCR0, 8'h00);
    wr(ADDR_BTR0, 8'h3F);
    rd(ADDR_BTR0, 8'h01);
    // Eleven bits of 8 quanta at prescaler 2 is 176 clocks
    waitCnt = 0;
    while (busSynced_q !== 1'b1 && waitCnt < 400) begin
      @(posedge sys_clk);
      waitCnt++;
    end
    chkPin(waitCnt >= 150 && waitCnt <= 194, 1'b1);
    rd(ADDR_MCR0, 8'h10);
    engTimerOut <= 1'b1;
    wr(ADDR_MCR0, 8'h08);
    // Timer input is registered behind the link bit
    @(posedge sys_clk);
    chkPin(timerIn_q, 1'b1);
    wr(ADDR_MCR0, 8'h0A);
    @(posedge sys_clk);
    chkPin(slpAck_q, 1'b1);
    engTxBit <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chkPin(slpAck_q, 1'b0);
    engTxBit <= 1'b1;
    rd(ADDR_RFLG, 8'h80);
    rd(ADDR_MCR0, 8'h18);
    wr(ADDR_MCR0, 8'h01);
    chkPin(busSynced_q, 1'b0);
    rd(ADDR_MCR0, 8'h01);
    rd(ADDR_TXERR, txErr);
    final_report();
  end
endmodule : can_mode_and_bit_timing_control_tb
